// File: core/ttg_pkg.sv
// Package for the triple timer group: register map, fields, modes and state type
package ttg_pkg;

  localparam int unsigned NUM_TMR  = 3;
  localparam int unsigned IDX_CORE = 0;
  localparam int unsigned IDX_A    = 1;
  localparam int unsigned IDX_B    = 2;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned NUM_FLAG = 5;
  localparam int unsigned FLAG_CAP = 2;

  // APB byte offsets
  localparam logic [7:0] OFS_CTRL_CORE = 8'h00;
  localparam logic [7:0] OFS_CTRL_A    = 8'h04;
  localparam logic [7:0] OFS_CTRL_B    = 8'h08;
  localparam logic [7:0] OFS_CNT_CORE  = 8'h0C;
  localparam logic [7:0] OFS_CNT_A     = 8'h10;
  localparam logic [7:0] OFS_CNT_B     = 8'h14;
  localparam logic [7:0] OFS_FLAGS     = 8'h18;
  localparam logic [7:0] OFS_LATCH     = 8'h1C;

  // Control register fields
  localparam int unsigned F_MODE     = 0;
  localparam int unsigned F_PRE      = 3;
  localparam int unsigned F_RUN      = 6;
  localparam int unsigned F_DIR      = 7;
  localparam int unsigned F_DIR_EXT  = 8;
  localparam int unsigned F_EDGE     = 9;
  localparam int unsigned F_GATE     = 11;
  localparam int unsigned F_SRC_OTL  = 12;
  localparam int unsigned F_LEDGE    = 13;
  localparam int unsigned F_EXT_TRIG = 15;
  localparam int unsigned ES_RISE    = 0;
  localparam int unsigned ES_FALL    = 1;

  // Latch register fields
  localparam int unsigned F_LATCH_VAL = 0;
  localparam int unsigned F_LATCH_OE  = 1;

  // Timer modes
  localparam logic [2:0] MODE_TIMER   = 3'h0;
  localparam logic [2:0] MODE_GATED   = 3'h1;
  localparam logic [2:0] MODE_COUNTER = 3'h2;
  localparam logic [2:0] MODE_ENCODER = 3'h3;
  localparam logic [2:0] MODE_RELOAD  = 3'h4;
  localparam logic [2:0] MODE_CAPTURE = 3'h5;

  // Base tick: one count step per four system clocks
  localparam int unsigned BASE_CYCLES   = 4;
  localparam logic [1:0]  BASE_DIV_LAST = 2'(BASE_CYCLES - 1);

  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_MIN   = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic [NUM_TMR-1:0][CNT_W-1:0] ctrl;
    logic [NUM_TMR-1:0][CNT_W-1:0] cnt;
    logic [NUM_FLAG-1:0]           flags;
    logic                          latch;
    logic                          latch_oe;
    logic                          latch_prev;
    logic [1:0]                    div;
    logic [7:0]                    pre;
    logic [2:0]                    s1;
    logic [2:0]                    s2;
    logic [2:0]                    s3;
    logic [2:0]                    lvl;
    logic [2:0]                    prev;
    logic                          out;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } ttg_state_t;

endpackage : ttg_pkg

// File: core/ttg_timer_group_one.sv
// Triple 16-bit timer group with APB registers, toggle latch and reload/capture
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ttg_timer_group_one (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        core_count_gate_input,
  input  wire logic        core_direction_input,
  input  wire logic        aux_b_count_gate_input,
  output logic             toggle_latch_output
);

  ttg_pkg::ttg_state_t s;
  ttg_pkg::ttg_state_t next_s;

  logic [ttg_pkg::NUM_TMR-1:0] step;
  logic [ttg_pkg::NUM_TMR-1:0] ovf;
  logic [ttg_pkg::NUM_TMR-1:0] cap_ev;
  logic [ttg_pkg::NUM_TMR-1:0] rld_ev;
  logic                        base;
  logic                        wr;

  // Low prescaler bits that must all be set for a prescaled tick
  function automatic logic [7:0] pre_mask(input logic [2:0] n);
    logic [7:0] m;
    m = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (k < int'(n)) begin
        m[k] = 1'b1;
      end
    end
    return m;
  endfunction : pre_mask

  // Edge selection: rise, fall or both
  function automatic logic sel_edge(input logic [1:0] es, input logic r, input logic f);
    return (es[ttg_pkg::ES_RISE] & r) | (es[ttg_pkg::ES_FALL] & f);
  endfunction : sel_edge

  function automatic logic [31:0] read_reg(input ttg_pkg::ttg_state_t st, input logic [7:0] a);
    logic [31:0] d;
    d = ttg_pkg::RDATA_RST;
    unique case (a)
      ttg_pkg::OFS_CTRL_CORE: d = {16'h0000, st.ctrl[ttg_pkg::IDX_CORE]};
      ttg_pkg::OFS_CTRL_A:    d = {16'h0000, st.ctrl[ttg_pkg::IDX_A]};
      ttg_pkg::OFS_CTRL_B:    d = {16'h0000, st.ctrl[ttg_pkg::IDX_B]};
      ttg_pkg::OFS_CNT_CORE:  d = {16'h0000, st.cnt[ttg_pkg::IDX_CORE]};
      ttg_pkg::OFS_CNT_A:     d = {16'h0000, st.cnt[ttg_pkg::IDX_A]};
      ttg_pkg::OFS_CNT_B:     d = {16'h0000, st.cnt[ttg_pkg::IDX_B]};
      ttg_pkg::OFS_FLAGS:     d = {27'h0000000, st.flags};
      ttg_pkg::OFS_LATCH:     d = {30'h00000000, st.latch_oe, st.latch};
      default:                d = ttg_pkg::RDATA_RST;
    endcase
    return d;
  endfunction : read_reg

  function automatic logic mapped(input logic [7:0] a);
    return (a == ttg_pkg::OFS_CTRL_CORE) || (a == ttg_pkg::OFS_CTRL_A) || (a == ttg_pkg::OFS_CTRL_B) ||
           (a == ttg_pkg::OFS_CNT_CORE) || (a == ttg_pkg::OFS_CNT_A) || (a == ttg_pkg::OFS_CNT_B) ||
           (a == ttg_pkg::OFS_FLAGS) || (a == ttg_pkg::OFS_LATCH);
  endfunction : mapped

  always_comb begin
    logic [2:0]  cin_l;
    logic [2:0]  cin_p;
    logic [2:0]  din_l;
    logic [2:0]  din_p;
    logic [2:0]  m;
    logic [15:0] c;
    logic [7:0]  pm;
    logic [1:0]  es;
    logic [1:0]  les;
    logic        lrise;
    logic        lfall;
    logic        ptick;
    logic        erise;
    logic        efall;
    logic        eev;
    logic        a_ch;
    logic        b_ch;
    logic        down;
    logic        run;
    logic [ttg_pkg::NUM_FLAG-1:0] fset;
    logic [ttg_pkg::NUM_FLAG-1:0] fclr;
    next_s = s;
    cin_l  = 3'h0;
    cin_p  = 3'h0;
    din_l  = 3'h0;
    din_p  = 3'h0;
    m      = ttg_pkg::MODE_TIMER;
    c      = ttg_pkg::CNT_MIN;
    pm     = 8'h00;
    es     = 2'h0;
    les    = 2'h0;
    ptick  = 1'b0;
    erise  = 1'b0;
    efall  = 1'b0;
    lrise  = 1'b0;
    lfall  = 1'b0;
    eev    = 1'b0;
    a_ch   = 1'b0;
    b_ch   = 1'b0;
    down   = 1'b0;
    run    = 1'b0;
    fset   = '0;
    fclr   = '0;
    step   = '0;
    ovf    = '0;
    cap_ev = '0;
    rld_ev = '0;

    wr = psel & penable & pwrite & s.pready;
    base = (s.div == ttg_pkg::BASE_DIV_LAST);
    next_s.div = 2'(s.div + 2'h1);
    if (base) begin
      next_s.pre = 8'(s.pre + 8'h01);
      next_s.prev = s.lvl;
    end

    // Pins settle when the second and third stages agree
    next_s.s1 = {aux_b_count_gate_input, core_direction_input, core_count_gate_input};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int k = 0; k < 3; k++) begin
      if (s.s2[k] == s.s3[k]) begin
        next_s.lvl[k] = s.s3[k];
      end
    end

    // Missing pins of the auxiliary timers stay low
    cin_l[ttg_pkg::IDX_CORE] = s.lvl[0];
    cin_p[ttg_pkg::IDX_CORE] = s.prev[0];
    din_l[ttg_pkg::IDX_CORE] = s.lvl[1];
    din_p[ttg_pkg::IDX_CORE] = s.prev[1];
    cin_l[ttg_pkg::IDX_B]    = s.lvl[2];
    cin_p[ttg_pkg::IDX_B]    = s.prev[2];

    lrise = s.latch & ~s.latch_prev;
    lfall = ~s.latch & s.latch_prev;
    next_s.latch_prev = s.latch;

    for (int i = 0; i < ttg_pkg::NUM_TMR; i++) begin
      m     = s.ctrl[i][ttg_pkg::F_MODE +: 3];
      run   = s.ctrl[i][ttg_pkg::F_RUN];
      pm    = pre_mask(s.ctrl[i][ttg_pkg::F_PRE +: 3]);
      es    = s.ctrl[i][ttg_pkg::F_EDGE +: 2];
      les   = s.ctrl[i][ttg_pkg::F_LEDGE +: 2];
      ptick = base & ((s.pre & pm) == pm);
      erise = base & cin_l[i] & ~cin_p[i];
      efall = base & ~cin_l[i] & cin_p[i];
      eev   = sel_edge(es, erise, efall);
      a_ch  = base & (cin_l[i] ^ cin_p[i]);
      b_ch  = base & (din_l[i] ^ din_p[i]);
      down  = s.ctrl[i][ttg_pkg::F_DIR] ^ (s.ctrl[i][ttg_pkg::F_DIR_EXT] & din_l[i]);
      unique case (m)
        ttg_pkg::MODE_TIMER: begin
          step[i] = ptick;
        end
        ttg_pkg::MODE_GATED: begin
          step[i] = ptick & (cin_l[i] == s.ctrl[i][ttg_pkg::F_GATE]);
        end
        ttg_pkg::MODE_COUNTER: begin
          if ((i != ttg_pkg::IDX_CORE) && s.ctrl[i][ttg_pkg::F_SRC_OTL]) begin
            step[i] = sel_edge(es, lrise, lfall);
          end else begin
            step[i] = eev;
          end
        end
        ttg_pkg::MODE_ENCODER: begin
          step[i] = a_ch | b_ch;
          down = a_ch ? ~(cin_l[i] ^ din_l[i]) : (cin_l[i] ^ din_l[i]);
        end
        ttg_pkg::MODE_RELOAD: begin
          if (i != ttg_pkg::IDX_CORE) begin
            rld_ev[i] = run & ((s.ctrl[i][ttg_pkg::F_EXT_TRIG] & eev) | sel_edge(les, lrise, lfall));
          end
        end
        ttg_pkg::MODE_CAPTURE: begin
          if (i != ttg_pkg::IDX_CORE) begin
            cap_ev[i] = run & eev;
          end
        end
        default: begin
          step[i] = 1'b0;
        end
      endcase
      // Reload and capture modes leave step low, so the timer holds
      step[i] = step[i] & run;
      c = s.cnt[i];
      ovf[i] = step[i] & (down ? (c == ttg_pkg::CNT_MIN) : (c == ttg_pkg::CNT_MAX));
      if (step[i]) begin
        next_s.cnt[i] = down ? 16'(c - ttg_pkg::CNT_ONE) : 16'(c + ttg_pkg::CNT_ONE);
      end
      if (cap_ev[i]) begin
        next_s.cnt[i] = s.cnt[ttg_pkg::IDX_CORE];
        fset[ttg_pkg::FLAG_CAP + i] = 1'b1;
      end
      fset[i] = fset[i] | ovf[i];
    end

    // Reload beats counting; if both fire, timer a wins
    if (rld_ev[ttg_pkg::IDX_B]) begin
      next_s.cnt[ttg_pkg::IDX_CORE] = s.cnt[ttg_pkg::IDX_B];
    end
    if (rld_ev[ttg_pkg::IDX_A]) begin
      next_s.cnt[ttg_pkg::IDX_CORE] = s.cnt[ttg_pkg::IDX_A];
    end

    if (ovf[ttg_pkg::IDX_CORE]) begin
      next_s.latch = ~s.latch;
    end

    // Software writes; a counter write overrides hardware that cycle
    if (wr) begin
      unique case (paddr)
        ttg_pkg::OFS_CTRL_CORE: next_s.ctrl[ttg_pkg::IDX_CORE] = pwdata[15:0];
        ttg_pkg::OFS_CTRL_A:    next_s.ctrl[ttg_pkg::IDX_A]    = pwdata[15:0];
        ttg_pkg::OFS_CTRL_B:    next_s.ctrl[ttg_pkg::IDX_B]    = pwdata[15:0];
        ttg_pkg::OFS_CNT_CORE:  next_s.cnt[ttg_pkg::IDX_CORE]  = pwdata[15:0];
        ttg_pkg::OFS_CNT_A:     next_s.cnt[ttg_pkg::IDX_A]     = pwdata[15:0];
        ttg_pkg::OFS_CNT_B:     next_s.cnt[ttg_pkg::IDX_B]     = pwdata[15:0];
        ttg_pkg::OFS_FLAGS:     fclr = pwdata[ttg_pkg::NUM_FLAG-1:0];
        ttg_pkg::OFS_LATCH: begin
          next_s.latch    = pwdata[ttg_pkg::F_LATCH_VAL];
          next_s.latch_oe = pwdata[ttg_pkg::F_LATCH_OE];
        end
        default: begin
        end
      endcase
    end
    // Set wins over a write-one clear so no event is lost
    next_s.flags = (s.flags & ~fclr) | fset;

    next_s.out = s.latch & s.latch_oe;

    // One wait-free access: answer is registered in the setup cycle
    if (psel & ~penable & ~s.pready) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = ~mapped(paddr);
      next_s.prdata  = pwrite ? ttg_pkg::RDATA_RST : read_reg(s, paddr);
    end else begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata              = s.prdata;
  assign pready              = s.pready;
  assign pslverr             = s.pslverr;
  assign toggle_latch_output = s.out;

  // Checks
  chk_base_period: assert property (@(posedge pclk) disable iff (!presetn)
    base |=> !base [*3] ##1 base) else $error("base tick period is not four clocks");

  chk_wrap_up: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf[0] && !wr && !rld_ev[1] && !rld_ev[2] && s.cnt[0] == ttg_pkg::CNT_MAX)
      |=> (s.cnt[0] == ttg_pkg::CNT_MIN) && s.flags[0]) else $error("core up wrap wrong");

  chk_wrap_down: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf[0] && !wr && !rld_ev[1] && !rld_ev[2] && s.cnt[0] == ttg_pkg::CNT_MIN)
      |=> (s.cnt[0] == ttg_pkg::CNT_MAX)) else $error("core down wrap wrong");

  chk_latch_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf[0] && !wr) |=> (s.latch != $past(s.latch))) else $error("latch did not toggle");

  chk_latch_pin: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 toggle_latch_output == ($past(s.latch) & $past(s.latch_oe))) else $error("latch pin mismatch");

  chk_aux_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ctrl[1][ttg_pkg::F_MODE +: 3] == ttg_pkg::MODE_RELOAD && !wr) |=> $stable(s.cnt[1]))
    else $error("reload timer counted");

  chk_capture_val: assert property (@(posedge pclk) disable iff (!presetn)
    (cap_ev[2] && !wr) |=> (s.cnt[2] == $past(s.cnt[0])) && s.flags[ttg_pkg::FLAG_CAP + ttg_pkg::IDX_B])
    else $error("capture wrong");

  chk_reload_val: assert property (@(posedge pclk) disable iff (!presetn)
    (rld_ev[1] && !wr) |=> (s.cnt[0] == $past(s.cnt[1]))) else $error("reload wrong");

  chk_step_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    step[0] |=> !step[0] [*3]) else $error("core stepped faster than four clocks");

  chk_gate_block: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ctrl[0][ttg_pkg::F_MODE +: 3] == ttg_pkg::MODE_GATED &&
     s.lvl[0] != s.ctrl[0][ttg_pkg::F_GATE]) |-> !step[0]) else $error("gate closed but counted");

  chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (s.flags[0] && !wr) |=> s.flags[0]) else $error("flag lost without clear");

  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pready) |=> pready ##1 !pready) else $error("pready not one cycle");

  chk_timer_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ctrl[0][ttg_pkg::F_MODE +: 3] == ttg_pkg::MODE_TIMER && s.ctrl[0][ttg_pkg::F_RUN] &&
     !(|s.ctrl[0][ttg_pkg::F_PRE +: 3])) |-> (step[0] == base)) else $error("timer tick mismatch");

  chk_gate_open: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ctrl[0][ttg_pkg::F_MODE +: 3] == ttg_pkg::MODE_GATED && s.ctrl[0][ttg_pkg::F_RUN] &&
     !(|s.ctrl[0][ttg_pkg::F_PRE +: 3]) && s.lvl[0] == s.ctrl[0][ttg_pkg::F_GATE]) |-> (step[0] == base))
    else $error("open gate did not count");

  chk_count_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ctrl[2][ttg_pkg::F_MODE +: 3] == ttg_pkg::MODE_COUNTER && s.ctrl[2][ttg_pkg::F_RUN] &&
     !s.ctrl[2][ttg_pkg::F_SRC_OTL] && s.ctrl[2][ttg_pkg::F_EDGE + ttg_pkg::ES_RISE] &&
     !s.ctrl[2][ttg_pkg::F_EDGE + ttg_pkg::ES_FALL]) |-> (step[2] == (base && s.lvl[2] && !s.prev[2])))
    else $error("counter edge mismatch");

  chk_dir_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (step[0] && !wr && !rld_ev[1] && !rld_ev[2] && s.ctrl[0][ttg_pkg::F_MODE +: 3] == ttg_pkg::MODE_TIMER &&
     s.ctrl[0][ttg_pkg::F_DIR_EXT] && !s.ctrl[0][ttg_pkg::F_DIR] && s.lvl[1])
      |=> (s.cnt[0] == 16'($past(s.cnt[0]) - ttg_pkg::CNT_ONE))) else $error("direction pin ignored");

  chk_encoder_up: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ctrl[0][ttg_pkg::F_MODE +: 3] == ttg_pkg::MODE_ENCODER && s.ctrl[0][ttg_pkg::F_RUN] && base && !wr &&
     !rld_ev[1] && !rld_ev[2] && s.lvl[0] != s.prev[0] && s.lvl[0] != s.lvl[1])
      |=> (s.cnt[0] == 16'($past(s.cnt[0]) + ttg_pkg::CNT_ONE))) else $error("encoder did not count up");

  chk_latch_clock: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ctrl[1][ttg_pkg::F_MODE +: 3] == ttg_pkg::MODE_COUNTER && s.ctrl[1][ttg_pkg::F_RUN] &&
     s.ctrl[1][ttg_pkg::F_SRC_OTL] && s.ctrl[1][ttg_pkg::F_EDGE + ttg_pkg::ES_RISE] &&
     !s.ctrl[1][ttg_pkg::F_DIR] && s.latch && !s.latch_prev && !wr)
      |=> (s.cnt[1] == 16'($past(s.cnt[1]) + ttg_pkg::CNT_ONE)))
    else $error("latch edge did not clock timer a");

  chk_reload_b: assert property (@(posedge pclk) disable iff (!presetn)
    (rld_ev[2] && !rld_ev[1] && !wr) |=> (s.cnt[0] == $past(s.cnt[2]))) else $error("reload from timer b wrong");

  cov_core_wrap:  cover property (@(posedge pclk) disable iff (!presetn) ovf[0]);
  cov_ext_reload: cover property (@(posedge pclk) disable iff (!presetn) rld_ev[2]);
  cov_capture:    cover property (@(posedge pclk) disable iff (!presetn) cap_ev[2]);
  cov_pwm:        cover property (@(posedge pclk) disable iff (!presetn) rld_ev[1] ##[1:1000] rld_ev[2]);
  cov_encoder:    cover property (@(posedge pclk) disable iff (!presetn)
    step[0] && s.ctrl[0][ttg_pkg::F_MODE +: 3] == ttg_pkg::MODE_ENCODER);

endmodule : ttg_timer_group_one
`default_nettype wire

// File: verification/ttg_pin_model.sv
// Pin-side model: count/gate, direction/encoder and aux capture pin drivers
`timescale 1ns/100ps
`default_nettype none
module ttg_pin_model (
  input  wire logic pclk,
  output var logic  core_count_gate_input,
  output var logic  core_direction_input,
  output var logic  aux_b_count_gate_input
);
  // Levels are held 16 clocks; the pin path needs about 8 to see a change
  localparam int HOLD = 16;
  initial begin
    core_count_gate_input  = 1'b0;
    core_direction_input   = 1'b0;
    aux_b_count_gate_input = 1'b0;
  end
  task automatic set_core(input logic a, input logic b);
    @(posedge pclk);
    core_count_gate_input <= a;
    core_direction_input  <= b;
    repeat (HOLD) @(posedge pclk);
  endtask : set_core
  task automatic pulse_b(input int n);
    repeat (n) begin
      @(posedge pclk);
      aux_b_count_gate_input <= 1'b1;
      repeat (HOLD) @(posedge pclk);
      aux_b_count_gate_input <= 1'b0;
      repeat (HOLD) @(posedge pclk);
    end
  endtask : pulse_b
endmodule : ttg_pin_model
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the triple timer group
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic        err;
  } ttg_row_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cgi;
  logic        cdir;
  logic        bgi;
  logic        toggle_latch_output;
  int          miscompares;
  int          cmp_count;
  int          cycles;
  int          hi;
  logic [31:0] v;
  logic [31:0] c;
  logic        e;
  // Reads carry the expected value in data; writes carry the written value
  ttg_row_t rows [10] = '{
    '{1'b0, ttg_pkg::OFS_CTRL_CORE, 32'h0000_0000, 1'b0},
    '{1'b0, ttg_pkg::OFS_CNT_CORE, 32'h0000_0000, 1'b0},
    '{1'b0, ttg_pkg::OFS_FLAGS, 32'h0000_0000, 1'b0},
    '{1'b0, ttg_pkg::OFS_LATCH, 32'h0000_0000, 1'b0},
    '{1'b1, ttg_pkg::OFS_CTRL_B, 32'hFFFF_0007, 1'b0},
    '{1'b0, ttg_pkg::OFS_CTRL_B, 32'h0000_0007, 1'b0},
    '{1'b1, ttg_pkg::OFS_CNT_A, 32'hABCD_1234, 1'b0},
    '{1'b0, ttg_pkg::OFS_CNT_A, 32'h0000_1234, 1'b0},
    '{1'b1, 8'h20, 32'h0000_005A, 1'b1},
    '{1'b0, 8'h20, 32'h0000_0000, 1'b1}
  };
  ttg_timer_group_one dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_count_gate_input(cgi),
    .core_direction_input(cdir), .aux_b_count_gate_input(bgi),
    .toggle_latch_output(toggle_latch_output)
  );
  ttg_pin_model pins (
    .pclk(pclk), .core_count_gate_input(cgi),
    .core_direction_input(cdir), .aux_b_count_gate_input(bgi)
  );
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // Whole run is under two thousand cycles; the ceiling leaves wide margin
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Pin synchronisers blur timing by a few clocks, so counts get a window
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] rd);
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
  endtask : rdr
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    idle(2);
    chk({30'h0, pready, toggle_latch_output}, 32'h0);
    idle(3);
    presetn <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data, v, e);
      chk({31'h0, e}, {31'h0, rows[i].err});
      if (!rows[i].wr) chk(v, rows[i].data);
    end
    $display("test registers done");
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0000_0040);
    idle(200);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0);
    rdr(ttg_pkg::OFS_CNT_CORE, v);
    chk_rng(v, 32'd48, 32'd53);
    wr(ttg_pkg::OFS_CNT_CORE, 32'h0);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0000_00C0);
    idle(20);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0);
    rdr(ttg_pkg::OFS_CNT_CORE, v);
    chk_rng(v, 32'hFFF8, 32'hFFFF);
    rdr(ttg_pkg::OFS_FLAGS, v);
    chk(v, 32'h1);
    rdr(ttg_pkg::OFS_LATCH, v);
    chk(v, 32'h1);
    wr(ttg_pkg::OFS_LATCH, 32'h3);
    idle(2);
    chk({31'h0, toggle_latch_output}, 32'h1);
    wr(ttg_pkg::OFS_FLAGS, 32'h1);
    rdr(ttg_pkg::OFS_FLAGS, v);
    chk(v, 32'h0);
    $display("test wrap done");
    wr(ttg_pkg::OFS_LATCH, 32'h2);
    wr(ttg_pkg::OFS_CTRL_A, 32'h0000_2044);
    wr(ttg_pkg::OFS_CNT_CORE, 32'h0);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0000_00C0);
    idle(30);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0);
    rdr(ttg_pkg::OFS_CNT_CORE, v);
    chk_rng(v, 32'h1228, 32'h1234);
    rdr(ttg_pkg::OFS_CNT_A, v);
    chk(v, 32'h1234);
    chk({31'h0, toggle_latch_output}, 32'h1);
    wr(ttg_pkg::OFS_CTRL_A, 32'h0);
    wr(ttg_pkg::OFS_FLAGS, 32'h1F);
    $display("test reload done");
    wr(ttg_pkg::OFS_CNT_B, 32'h0);
    wr(ttg_pkg::OFS_CTRL_B, 32'h0000_0242);
    pins.pulse_b(5);
    rdr(ttg_pkg::OFS_CNT_B, v);
    chk(v, 32'h5);
    $display("test counter done");
    wr(ttg_pkg::OFS_CTRL_B, 32'h0000_0245);
    wr(ttg_pkg::OFS_CNT_B, 32'hFFFF);
    wr(ttg_pkg::OFS_CNT_CORE, 32'h0);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0000_0040);
    pins.pulse_b(1);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0);
    rdr(ttg_pkg::OFS_CNT_CORE, c);
    rdr(ttg_pkg::OFS_CNT_B, v);
    chk_rng(v, 32'h0, c);
    rdr(ttg_pkg::OFS_FLAGS, v);
    chk(v & 32'h10, 32'h10);
    $display("test capture done");
    wr(ttg_pkg::OFS_CNT_CORE, 32'h0);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0000_0841);
    idle(100);
    rdr(ttg_pkg::OFS_CNT_CORE, v);
    chk(v, 32'h0);
    pins.set_core(1'b1, 1'b0);
    idle(100);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0);
    rdr(ttg_pkg::OFS_CNT_CORE, v);
    chk_rng(v, 32'd26, 32'd31);
    pins.set_core(1'b0, 1'b0);
    $display("test gated done");
    pins.set_core(1'b0, 1'b1);
    wr(ttg_pkg::OFS_CNT_CORE, 32'h0000_0100);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0000_0140);
    idle(40);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0);
    rdr(ttg_pkg::OFS_CNT_CORE, v);
    chk_rng(v, 32'h0000_00F3, 32'h0000_00F7);
    pins.set_core(1'b0, 1'b0);
    $display("test direction done");
    wr(ttg_pkg::OFS_CNT_CORE, 32'h0);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0000_0043);
    pins.set_core(1'b1, 1'b0);
    pins.set_core(1'b1, 1'b1);
    pins.set_core(1'b0, 1'b1);
    pins.set_core(1'b0, 1'b0);
    rdr(ttg_pkg::OFS_CNT_CORE, v);
    chk(v, 32'h4);
    pins.set_core(1'b0, 1'b1);
    pins.set_core(1'b1, 1'b1);
    rdr(ttg_pkg::OFS_CNT_CORE, v);
    chk(v, 32'h2);
    $display("test encoder done");
    // High time 2 and low time 4 give 12 high and 20 low clocks per period
    wr(ttg_pkg::OFS_LATCH, 32'h2);
    wr(ttg_pkg::OFS_CNT_A, 32'h2);
    wr(ttg_pkg::OFS_CNT_B, 32'h4);
    wr(ttg_pkg::OFS_CNT_CORE, 32'h0);
    wr(ttg_pkg::OFS_CTRL_A, 32'h0000_2044);
    wr(ttg_pkg::OFS_CTRL_B, 32'h0000_4044);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0000_00C0);
    idle(64);
    hi = 0;
    repeat (320) begin
      @(posedge pclk);
      hi += int'(toggle_latch_output);
    end
    chk(32'(hi), 32'd120);
    wr(ttg_pkg::OFS_CTRL_CORE, 32'h0);
    wr(ttg_pkg::OFS_CTRL_B, 32'h0);
    wr(ttg_pkg::OFS_CNT_A, 32'h0);
    wr(ttg_pkg::OFS_LATCH, 32'h2);
    wr(ttg_pkg::OFS_CTRL_A, 32'h0000_1242);
    repeat (3) begin
      wr(ttg_pkg::OFS_LATCH, 32'h3);
      wr(ttg_pkg::OFS_LATCH, 32'h2);
    end
    rdr(ttg_pkg::OFS_CNT_A, v);
    chk(v, 32'h3);
    wr(ttg_pkg::OFS_CTRL_A, 32'h0);
    wr(ttg_pkg::OFS_CNT_B, 32'h0000_0ABC);
    wr(ttg_pkg::OFS_CTRL_B, 32'h0000_8244);
    pins.pulse_b(1);
    rdr(ttg_pkg::OFS_CNT_CORE, v);
    chk(v, 32'h0000_0ABC);
    $display("test pwm done");
    wr(ttg_pkg::OFS_LATCH, 32'h3);
    idle(2);
    chk({31'h0, toggle_latch_output}, 32'h1);
    presetn <= 1'b0;
    idle(2);
    chk({30'h0, pready, toggle_latch_output}, 32'h0);
    presetn <= 1'b1;
    rdr(ttg_pkg::OFS_CTRL_B, v);
    chk(v, 32'h0);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
